// ===== rtl/ep0_handshake.sv
// handshake choice for in endpoint 0
`timescale 1ns/1ps
`default_nettype none
module ep0_handshake
    import usb_ep0_pkg::*;
(
    // tokens
    input wire logic inToken,
    input wire logic setupData,
    // endpoint state
    input wire logic stall,
    input wire logic nakState,
    input wire logic globalInNak,
    input wire logic globalOutNak,
    input wire logic fifoHasData,
    // answer
    output handshake_type answer,
    output logic sendData
);
    // stall over nak, setup always acked
    always_comb begin
        answer = HS_NONE;
        sendData = 1'b0;
        if (setupData) begin
            answer = HS_ACK;
        end else if (inToken) begin
            if (stall) begin
                answer = HS_STALL;
            end else if (nakState || globalInNak || globalOutNak || !fifoHasData) begin
                answer = HS_NAK;
            end else begin
                sendData = 1'b1;
            end
        end
    end
endmodule // ep0_handshake
`default_nettype wire

// ===== rtl/session_timer.sv
// supply pulse and discharge timer for a session request
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep0_params.svh"
module session_timer
    import usb_ep0_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // control side
    session_timer_if.timer tif
);
    typedef struct packed {
        session_state_type state;
        logic [`PRESCALE_BITS-1:0] prescale;
        logic [15:0] units;
        logic done;
    } timer_state_type;

    timer_state_type cur, next_cur;
    logic tick;

    // prescaler tick, unit compare and phase sequencing
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.prescale = cur.prescale + 1'b1;
        tick = (cur.prescale == {`PRESCALE_BITS{1'b1}});
        case (cur.state)
            SESS_IDLE: begin
                if (tif.start) begin
                    next_cur.state = SESS_PULSE;
                    next_cur.units = 16'h0;
                    next_cur.prescale = '0;
                end
            end
            SESS_PULSE: begin
                if (tick) begin
                    next_cur.units = cur.units + 16'h1;
                    if (cur.units + 16'h1 >= {4'h0, tif.pulseTime}) begin
                        next_cur.state = SESS_DISCHARGE;
                        next_cur.units = 16'h0;
                    end
                end
            end
            SESS_DISCHARGE: begin
                if (tick) begin
                    next_cur.units = cur.units + 16'h1;
                    if (cur.units + 16'h1 >= tif.dischargeTime) begin
                        next_cur.state = SESS_IDLE;
                        next_cur.done = 1'b1;
                    end
                end
            end
            default: next_cur.state = SESS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tif.supplyPulse = (cur.state == SESS_PULSE);
    assign tif.busy = (cur.state != SESS_IDLE);
    assign tif.done = cur.done;
endmodule // session_timer
`default_nettype wire

// ===== rtl/usb_ep0_in_ctrl.sv
// register file and control of in endpoint 0 with session request timing
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep0_params.svh"
// Functional notes
// - discharge time 16 bits, 1024 clocks each
// - pulse time 12 bits, 1024 clocks each
// - pulse first, then discharge interval
// - per-endpoint fifo empty interrupt mask
// - go bit cleared before disable/complete interrupt
// - stop request halts, cleared before interrupt
// - set nak by write or setup
// - clear nak by write
// - four-bit tx fifo select field
// - stall set by software, cleared by setup
// - stall beats any nak
// - endpoint type reads fixed 00
// - nak state bit shows nak handshaking
// - nak state blocks data transmission
// - setup data always acked
// - active flag reads one
// - max packet code 64/32/16/8 bytes
module usb_ep0_in_ctrl
    import usb_ep0_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    // usb side events
    input wire logic inToken,
    input wire logic setupReceived,
    input wire logic setupData,
    input wire logic transferDone,
    input wire logic globalInNak,
    input wire logic globalOutNak,
    input wire logic fifoHasData,
    input wire logic [15:0] txFifoEmptyEvent,
    // usb side answers
    output handshake_type answer,
    output logic sendData,
    output logic [3:0] txFifoSelect,
    output logic [6:0] maxPacketBytes,
    output logic supplyPulse,
    // interrupts
    output logic irq
);
    typedef struct packed {
        logic [15:0] dischargeTime;
        logic [11:0] pulseTime;
        logic [15:0] fifoEmptyMask;
        logic endpointGo;
        logic stopRequest;
        logic [3:0] fifoSelect;
        logic stall;
        logic nakState;
        logic [1:0] maxPacketCode;
        logic [3:0] irqStatus;
        logic [3:0] irqMask;
        logic [15:0] fifoEmptyStatus;
        logic sessionStart;
        logic stopPending;
        logic completePending;
        logic [31:0] rdata;
    } ctrl_state_type;

    ctrl_state_type cur, next_cur;
    session_timer_if tif();
    handshake_type hsAnswer;
    logic hsData;
    logic wrDisch, wrPulse, wrMask, wrCtl, wrIrqSt, wrIrqMask, wrSess;
    logic [31:0] ctlWord;
    logic [3:0] irqSet;
    logic [15:0] fifoSet;

    // ---------------------------------------------------------------
    // submodules
    // ---------------------------------------------------------------
    session_timer u_timer (
        .core_clk(core_clk),
        .srst(srst),
        .tif(tif)
    );

    ep0_handshake u_hs (
        .inToken(inToken),
        .setupData(setupData),
        .stall(cur.stall),
        .nakState(cur.nakState),
        .globalInNak(globalInNak),
        .globalOutNak(globalOutNak),
        .fifoHasData(fifoHasData && cur.endpointGo),
        .answer(hsAnswer),
        .sendData(hsData)
    );

    assign tif.start = cur.sessionStart;
    assign tif.dischargeTime = cur.dischargeTime;
    assign tif.pulseTime = cur.pulseTime;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    assign wrDisch = regWrite && (regAddr == `OFF_DISCHARGE_TIME);
    assign wrPulse = regWrite && (regAddr == `OFF_PULSE_TIME);
    assign wrMask = regWrite && (regAddr == `OFF_FIFO_EMPTY_MASK);
    assign wrCtl = regWrite && (regAddr == `OFF_EP0_CONTROL);
    assign wrIrqSt = regWrite && (regAddr == `OFF_IRQ_STATUS);
    assign wrIrqMask = regWrite && (regAddr == `OFF_IRQ_MASK);
    assign wrSess = regWrite && (regAddr == `OFF_SESSION_CTRL);

    // control word as read back
    always_comb begin
        ctlWord = 32'h0;
        ctlWord[`BIT_GO] = cur.endpointGo;
        ctlWord[`BIT_STOP] = cur.stopRequest;
        ctlWord[`FIFO_SEL_HI:`FIFO_SEL_LO] = cur.fifoSelect;
        ctlWord[`BIT_STALL] = cur.stall;
        ctlWord[`TYPE_HI:`TYPE_LO] = `ENDPOINT_TYPE_CONTROL;
        ctlWord[`BIT_NAK_STATE] = cur.nakState;
        ctlWord[`BIT_ACTIVE] = 1'b1;
        ctlWord[1:0] = cur.maxPacketCode;
    end

    // ---------------------------------------------------------------
    // register and endpoint behaviour
    // ---------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        irqSet = 4'h0;
        fifoSet = 16'h0;
        next_cur.sessionStart = 1'b0;
        next_cur.completePending = 1'b0;
        next_cur.stopPending = 1'b0;
        if (wrDisch) begin
            next_cur.dischargeTime = regWdata[15:0];
        end
        if (wrPulse) begin
            next_cur.pulseTime = regWdata[11:0];
        end
        if (wrMask) begin
            next_cur.fifoEmptyMask = regWdata[15:0];
        end
        if (wrIrqMask) begin
            next_cur.irqMask = regWdata[3:0];
        end
        if (wrSess && regWdata[0] && !tif.busy) begin
            next_cur.sessionStart = 1'b1;
        end
        if (wrCtl) begin
            next_cur.fifoSelect = regWdata[`FIFO_SEL_HI:`FIFO_SEL_LO];
            next_cur.maxPacketCode = regWdata[1:0];
            if (regWdata[`BIT_GO]) begin
                next_cur.endpointGo = 1'b1;
            end
            if (regWdata[`BIT_STOP] && cur.endpointGo) begin
                next_cur.stopRequest = 1'b1;
            end
            if (regWdata[`BIT_STALL]) begin
                next_cur.stall = 1'b1;
            end
            if (regWdata[`BIT_CLEAR_NAK]) begin
                next_cur.nakState = 1'b0;
            end
            if (regWdata[`BIT_SET_NAK]) begin
                next_cur.nakState = 1'b1;
            end
        end
        // setup arrival: nak set and stall cleared
        if (setupReceived) begin
            next_cur.nakState = 1'b1;
            next_cur.stall = 1'b0;
        end
        // stop request: drop go and request, flag disabled next cycle
        if (cur.stopRequest) begin
            next_cur.endpointGo = 1'b0;
            next_cur.stopRequest = 1'b0;
            next_cur.stopPending = 1'b1;
        end else if (transferDone && cur.endpointGo) begin
            next_cur.endpointGo = 1'b0;
            next_cur.completePending = 1'b1;
        end
        // disabled and complete interrupts raised one cycle after the go bit has cleared
        irqSet[`IRQ_DISABLED] = cur.stopPending;
        irqSet[`IRQ_COMPLETE] = cur.completePending;
        irqSet[`IRQ_SESSION_DONE] = tif.done;
        fifoSet = txFifoEmptyEvent;
        irqSet[`IRQ_FIFO_EMPTY] = |(txFifoEmptyEvent & cur.fifoEmptyMask);
        // write one to clear, a set in the same cycle wins
        if (wrIrqSt) begin
            next_cur.irqStatus = cur.irqStatus & ~regWdata[3:0];
        end
        if (wrMask && regWdata[31]) begin
            next_cur.fifoEmptyStatus = 16'h0;
        end
        next_cur.irqStatus = next_cur.irqStatus | irqSet;
        next_cur.fifoEmptyStatus = next_cur.fifoEmptyStatus | fifoSet;
        // read data, one cycle later, unmapped reads zero
        next_cur.rdata = 32'h0;
        if (regRead) begin
            case (regAddr)
                `OFF_DISCHARGE_TIME: next_cur.rdata = {16'h0, cur.dischargeTime};
                `OFF_PULSE_TIME: next_cur.rdata = {20'h0, cur.pulseTime};
                `OFF_FIFO_EMPTY_MASK: next_cur.rdata = {16'h0, cur.fifoEmptyMask};
                `OFF_EP0_CONTROL: next_cur.rdata = ctlWord;
                `OFF_IRQ_STATUS: next_cur.rdata = {28'h0, cur.irqStatus};
                `OFF_IRQ_MASK: next_cur.rdata = {28'h0, cur.irqMask};
                `OFF_SESSION_CTRL: next_cur.rdata = {30'h0, tif.supplyPulse, tif.busy};
                `OFF_EP0_STATUS: next_cur.rdata = {16'h0, cur.fifoEmptyStatus};
                default: next_cur.rdata = 32'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
            cur.dischargeTime <= `RST_DISCHARGE_TIME;
            cur.pulseTime <= `RST_PULSE_TIME;
        end else begin
            cur <= next_cur;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign regRdata = cur.rdata;
    assign answer = hsAnswer;
    assign sendData = hsData && !cur.nakState;
    assign txFifoSelect = cur.fifoSelect;
    assign maxPacketBytes = 7'h40 >> cur.maxPacketCode;
    assign supplyPulse = tif.supplyPulse;
    assign irq = |(cur.irqStatus & cur.irqMask);
endmodule // usb_ep0_in_ctrl
`default_nettype wire

// ===== shared/session_timer_if.sv
// carrier between the register file and the session timer
`timescale 1ns/1ps
`default_nettype none
interface session_timer_if;
    logic start;
    logic [15:0] dischargeTime;
    logic [11:0] pulseTime;
    logic supplyPulse;
    logic busy;
    logic done;
    modport ctrl (output start, output dischargeTime, output pulseTime,
        input supplyPulse, input busy, input done);
    modport timer (input start, input dischargeTime, input pulseTime,
        output supplyPulse, output busy, output done);
endinterface
`default_nettype wire

// ===== shared/usb_ep0_params.svh
// offsets, field positions, reset values and timing counts for the ep0 in slice
`ifndef USB_EP0_PARAMS_SVH
`define USB_EP0_PARAMS_SVH

`define OFF_DISCHARGE_TIME 12'h828
`define OFF_PULSE_TIME 12'h82c
`define OFF_FIFO_EMPTY_MASK 12'h834
`define OFF_EP0_CONTROL 12'h900
`define OFF_IRQ_STATUS 12'h840
`define OFF_IRQ_MASK 12'h844
`define OFF_SESSION_CTRL 12'h848
`define OFF_EP0_STATUS 12'h84c

`define RST_DISCHARGE_TIME 16'h17d7
`define RST_PULSE_TIME 12'h5b8

`define BIT_GO 31
`define BIT_STOP 30
`define BIT_SET_NAK 27
`define BIT_CLEAR_NAK 26
`define FIFO_SEL_HI 25
`define FIFO_SEL_LO 22
`define BIT_STALL 21
`define TYPE_HI 19
`define TYPE_LO 18
`define BIT_NAK_STATE 17
`define BIT_ACTIVE 15

`define PRESCALE_BITS 10
`define ENDPOINT_TYPE_CONTROL 2'h0

`define IRQ_DISABLED 0
`define IRQ_COMPLETE 1
`define IRQ_SESSION_DONE 2
`define IRQ_FIFO_EMPTY 3

`endif

// ===== shared/usb_ep0_pkg.sv
// types for the ep0 in slice
package usb_ep0_pkg;
    typedef enum logic [1:0] {SESS_IDLE, SESS_PULSE, SESS_DISCHARGE} session_state_type;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} handshake_type;
endpackage

// ===== verification/usb_ep0_in_ctrl_assertions.sv
// port level checks of the ep0 in slice
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep0_params.svh"
module usb_ep0_in_ctrl_assertions
    import usb_ep0_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // register port
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    // usb side
    input wire logic setupData,
    input wire logic fifoHasData,
    input var handshake_type answer,
    input wire logic sendData,
    input wire logic [3:0] txFifoSelect,
    input wire logic [6:0] maxPacketBytes,
    input wire logic supplyPulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // length of the current supply pulse
    logic [15:0] pulseLen;
    always_ff @(posedge core_clk) begin
        // saturates so a long pulse cannot wrap below the minimum
        if (srst || !supplyPulse) begin
            pulseLen <= 16'h0;
        end else if (pulseLen != 16'hffff) begin
            pulseLen <= pulseLen + 16'h1;
        end
    end
    sequence ctl_read;
        $past(regRead) && $past(regAddr) == `OFF_EP0_CONTROL;
    endsequence
    sequence start_req;
        regWrite && regAddr == `OFF_SESSION_CTRL && regWdata[0];
    endsequence
    sequence pulse_end;
        $fell(supplyPulse);
    endsequence
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside the read answer cycle");
    ctl_fixed_a: assert property (ctl_read |-> regRdata[15] && regRdata[19:18] == 2'h0)
        else $error("type or active field wrong");
    ctl_match_a: assert property (ctl_read |-> regRdata[25:22] == txFifoSelect
        && maxPacketBytes == (7'h40 >> regRdata[1:0])) else $error("fifo select or size mismatch");
    packet_code_a: assert property (maxPacketBytes inside {7'h40, 7'h20, 7'h10, 7'h08})
        else $error("packet size not a legal value");
    setup_ack_a: assert property (setupData |-> answer == HS_ACK)
        else $error("setup data not acked");
    data_gate_a: assert property (sendData |-> fifoHasData && answer != HS_STALL)
        else $error("data sent while blocked");
    sel_change_a: assert property ($changed(txFifoSelect) |-> $past(regWrite) && $past(regAddr) == `OFF_EP0_CONTROL)
        else $error("fifo select changed without a write");
    pulse_start_a: assert property ($rose(supplyPulse) |-> $past(regWrite, 2)
        && $past(regAddr, 2) == `OFF_SESSION_CTRL)
        else $error("pulse without a session start");
    pulse_len_a: assert property (pulse_end |-> pulseLen >= 16'h0400)
        else $error("supply pulse too short");
    start_c: cover property (start_req);
endmodule // usb_ep0_in_ctrl_assertions
bind usb_ep0_in_ctrl usb_ep0_in_ctrl_assertions chk_i (.core_clk(core_clk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .setupData(setupData), .fifoHasData(fifoHasData), .answer(answer),
    .sendData(sendData), .txFifoSelect(txFifoSelect), .maxPacketBytes(maxPacketBytes),
    .supplyPulse(supplyPulse));
`default_nettype wire

// ===== verification/usb_ep0_in_ctrl_test.sv
// self-checking bench of the ep0 in slice
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep0_params.svh"
module usb_ep0_in_ctrl_test
    import usb_ep0_pkg::*;
;
    logic core_clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0, rdLate = 1'b0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWdata = 32'h0, regRdata, r;
    logic sendIn = 1'b0, sendSetup = 1'b0, finish = 1'b0, fifoHasData = 1'b0;
    logic globalInNak = 1'b0, globalOutNak = 1'b0, sendData, supplyPulse, irq;
    logic inToken, setupReceived, setupData, transferDone;
    logic [15:0] txFifoEmptyEvent = 16'h0;
    logic [3:0] txFifoSelect;
    logic [6:0] maxPacketBytes;
    handshake_type answer;
    logic [31:0] expQ[$], mskQ[$];
    int miscompares = 0, cmp_count = 0, n;
    initial forever #4 core_clk = ~core_clk;
    usb_ep0_in_ctrl uut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .inToken(inToken), .setupReceived(setupReceived), .setupData(setupData),
        .transferDone(transferDone), .globalInNak(globalInNak), .globalOutNak(globalOutNak),
        .fifoHasData(fifoHasData), .txFifoEmptyEvent(txFifoEmptyEvent), .answer(answer),
        .sendData(sendData), .txFifoSelect(txFifoSelect), .maxPacketBytes(maxPacketBytes),
        .supplyPulse(supplyPulse), .irq(irq));
    usb_host_model host_i (.core_clk(core_clk), .srst(srst), .sendIn(sendIn),
        .sendSetup(sendSetup), .finish(finish), .inToken(inToken),
        .setupReceived(setupReceived), .setupData(setupData), .transferDone(transferDone));
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one-cycle register strobes, each right after a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge core_clk);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
    endtask
    // host request: in, setup or transfer end; returns with the token settled
    task automatic host(input logic [2:0] k);
        @(posedge core_clk);
        {finish, sendSetup, sendIn} <= k;
        @(posedge core_clk);
        {finish, sendSetup, sendIn} <= 3'h0;
        @(negedge core_clk);
    endtask
    // read answers are taken off the queue in the cycle they stand
    always @(posedge core_clk) rdLate <= regRead;
    always @(negedge core_clk) begin
        if (rdLate) begin
            chk((regRdata & mskQ[0]) === expQ[0], "register read");
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
    end
    // watchdog
    initial begin
        #(8 * 20000);
        miscompares++;
        end_sim;
    end
    initial begin
        r = $urandom(32'hb402);
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        // reset values, unmapped place, random write and read back
        rd(`OFF_DISCHARGE_TIME, 32'h17d7, '1);
        rd(`OFF_PULSE_TIME, 32'h5b8, '1);
        rd(`OFF_FIFO_EMPTY_MASK, 32'h0, '1);
        rd(`OFF_EP0_CONTROL, 32'h8000, '1);
        rd(12'hffc, 32'h0, '1);
        r = $urandom;
        wr(`OFF_DISCHARGE_TIME, r);
        rd(`OFF_DISCHARGE_TIME, r & 32'hffff, '1);
        wr(`OFF_PULSE_TIME, r);
        rd(`OFF_PULSE_TIME, r & 32'hfff, '1);
        wr(`OFF_FIFO_EMPTY_MASK, ~r);
        rd(`OFF_FIFO_EMPTY_MASK, ~r & 32'hffff, '1);
        // every packet size code with a random fifo number, type bits written high
        for (int c = 0; c < 4; c++) begin
            r = $urandom;
            wr(`OFF_EP0_CONTROL, (r[3:0] << 22) | 32'hc0000 | c);
            rd(`OFF_EP0_CONTROL, (r[3:0] << 22) | 32'h8000 | c, 32'h03ffffff);
            chk(txFifoSelect === r[3:0] && maxPacketBytes === (7'h40 >> c), "select or size");
        end
        // nak set by write blocks data, clear nak lets it go
        fifoHasData <= 1'b1;
        wr(`OFF_EP0_CONTROL, 32'h88000000);
        rd(`OFF_EP0_CONTROL, 32'h80028000, 32'h80028000);
        host(3'h1);
        chk(answer === HS_NAK && sendData === 1'b0, "nak answer");
        wr(`OFF_EP0_CONTROL, 32'h84000000);
        rd(`OFF_EP0_CONTROL, 32'h80008000, 32'h80028000);
        host(3'h1);
        chk(sendData === 1'b1, "data after clear nak");
        // stall over every nak, then setup clears stall and sets nak
        wr(`OFF_EP0_CONTROL, 32'h88200000);
        globalInNak <= 1'b1;
        globalOutNak <= 1'b1;
        host(3'h1);
        chk(answer === HS_STALL && sendData === 1'b0, "stall priority");
        host(3'h2);
        @(negedge core_clk);
        chk(answer === HS_ACK, "setup data ack");
        rd(`OFF_EP0_CONTROL, 32'h20000, 32'h220000);
        globalInNak <= 1'b0;
        globalOutNak <= 1'b0;
        // completion clears go, raises status and irq, cleared by a one
        wr(`OFF_IRQ_STATUS, '1);
        wr(`OFF_IRQ_MASK, 32'hf);
        rd(`OFF_IRQ_MASK, 32'hf, '1);
        wr(`OFF_EP0_CONTROL, 32'h80000000);
        host(3'h4);
        repeat (3) @(posedge core_clk);
        rd(`OFF_EP0_CONTROL, 32'h0, 32'h80000000);
        rd(`OFF_IRQ_STATUS, 32'h2, 32'hf);
        chk(irq === 1'b1, "irq on completion");
        wr(`OFF_IRQ_STATUS, 32'h2);
        rd(`OFF_IRQ_STATUS, 32'h0, 32'hf);
        chk(irq === 1'b0, "irq after clear");
        // stop request on an enabled endpoint
        wr(`OFF_IRQ_MASK, 32'h0);
        wr(`OFF_EP0_CONTROL, 32'h80000000);
        wr(`OFF_EP0_CONTROL, 32'hc0000000);
        repeat (3) @(posedge core_clk);
        rd(`OFF_EP0_CONTROL, 32'h0, 32'hc0000000);
        rd(`OFF_IRQ_STATUS, 32'h1, 32'hf);
        chk(irq === 1'b0, "masked status keeps irq low");
        // fifo empty events: masked endpoint then unmasked endpoint 0
        wr(`OFF_IRQ_STATUS, '1);
        wr(`OFF_FIFO_EMPTY_MASK, 32'h1);
        for (int e = 0; e < 2; e++) begin
            @(posedge core_clk);
            txFifoEmptyEvent <= e ? 16'h0001 : 16'h0020;
            @(posedge core_clk);
            txFifoEmptyEvent <= 16'h0;
            repeat (2) @(posedge core_clk);
            rd(`OFF_IRQ_STATUS, e << 3, 32'h8);
        end
        // sticky per-endpoint events, cleared through mask bit 31
        rd(`OFF_EP0_STATUS, 32'h21, '1);
        wr(`OFF_FIFO_EMPTY_MASK, 32'h80000001);
        rd(`OFF_EP0_STATUS, 32'h0, '1);
        // session: pulse then discharge, one tick each
        wr(`OFF_PULSE_TIME, 32'h1);
        wr(`OFF_DISCHARGE_TIME, 32'h1);
        wr(`OFF_IRQ_STATUS, '1);
        wr(`OFF_SESSION_CTRL, 32'h1);
        n = 0;
        while (supplyPulse !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (supplyPulse === 1'b1 && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        chk(n >= 1015 && n <= 1030, "pulse length");
        rd(`OFF_IRQ_STATUS, 32'h0, 32'h4);
        rd(`OFF_SESSION_CTRL, 32'h1, '1);
        repeat (1100) @(posedge core_clk);
        rd(`OFF_IRQ_STATUS, 32'h4, 32'h4);
        rd(`OFF_SESSION_CTRL, 32'h0, '1);
        repeat (3) @(posedge core_clk);
        end_sim;
    end
endmodule // usb_ep0_in_ctrl_test
`default_nettype wire

// ===== verification/usb_host_model.sv
// usb host model that issues tokens and packets toward in endpoint 0
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // requests from the bench
    input wire logic sendIn,
    input wire logic sendSetup,
    input wire logic finish,
    // bus events toward the device
    output logic inToken,
    output logic setupReceived,
    output logic setupData,
    output logic transferDone
);
    // token first, the setup data packet one cycle behind it
    always_ff @(posedge core_clk) begin
        inToken <= sendIn && !srst;
        setupReceived <= sendSetup && !srst;
        setupData <= setupReceived && !srst;
        transferDone <= finish && !srst;
    end
endmodule // usb_host_model
`default_nettype wire
